// ==== verilog/cmws_pkg.sv ====
/*
 Package for the cellular modem word sync and transmit block: register map,
 field positions, reset values, timing constants and carrier structs.
 Assumes a 25 MHz core clock and an Avalon-MM slave with 32-bit data.
*/
package cmws_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CORE_CLK_HZ = 25000000;
   localparam int RX_TICK_KHZ = 504;
   localparam int RX_TICK_DIV = (CORE_CLK_HZ + RX_TICK_KHZ * 500) / (RX_TICK_KHZ * 1000);
   localparam int TX_BYTE_US_AMPS = 800;
   localparam int TX_BYTE_US_TACS = 1000;
   localparam int TX_BYTE_CYC_AMPS = TX_BYTE_US_AMPS * (CORE_CLK_HZ / 1000000);
   localparam int TX_BYTE_CYC_TACS = TX_BYTE_US_TACS * (CORE_CLK_HZ / 1000000);
   localparam int BITS_PER_BYTE = 8;
   localparam int HALF_BITS_PER_BYTE = 16;
   localparam int FRAME_BITS_DEFAULT = 463;
   localparam int BI_SPACING_DEFAULT = 10;

   // ==========================================================
   // Barker code and register map (word indices, not byte offsets)
   localparam logic [10:0] BARKER_CODE = 11'h712;
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_MODEM_PORT_ONE = 4'h1;
   localparam logic [3:0] ADDR_RX_DATA = 4'h2;
   localparam logic [3:0] ADDR_TX_DATA = 4'h3;
   localparam logic [3:0] ADDR_EVENTS = 4'h4;

   // Control register fields
   localparam int CTL_CHANNEL_TYPE = 0;
   localparam int CTL_REFRAME = 1;
   localparam int CTL_TX_ENABLE = 3;
   localparam int CTL_SYSTEM_TYPE = 4;
   localparam int CTL_TX_INVERT = 6;
   localparam logic [7:0] CONTROL_RESET = 8'h02;
   // Modem port one fields
   localparam int MP1_SQ_LSB = 0;
   localparam int MP1_BUSYIDLE = 6;

   typedef enum logic [3:0] {
      MODE_CC_SYNC = 4'h1,
      MODE_CC_UNSYNC = 4'h2,
      MODE_VC_FIXED = 4'h4,
      MODE_VC_REFRAME = 4'h8
   } cmws_mode_type;

   typedef struct packed {
      logic word_sync;
      logic rx_byte;
      logic busyidle_or_sat;
      logic tx_tick;
   } cmws_events_type;

   typedef struct packed {
      logic [7:0] data;
      logic [3:0] squelch;
   } cmws_rx_byte_type;
endpackage

// ==== verilog/cmws_tx.sv ====
/*
 Transmit half: byte tick timer, shift register and Manchester encoder.
 Assumes the data byte and control bits come from registers on core_clk.
*/
`timescale 1ns/1ps
module cmws_tx (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] tx_data,
   input wire logic tx_enable,
   input wire logic tx_invert,
   input wire logic system_type_select,
   output logic tx_tick,
   output logic tx_serial
);
   import cmws_pkg::*;

   logic [15:0] tick_count, next_tick_count;
   logic [15:0] half_count, next_half_count;
   logic [3:0] half_index, next_half_index;
   logic [7:0] shift, next_shift;
   logic sending, next_sending;
   logic next_tx_serial;
   logic [15:0] byte_period;
   logic [15:0] half_period;
   logic tick_now;

   always_comb begin
      byte_period = system_type_select ? 16'(TX_BYTE_CYC_TACS) : 16'(TX_BYTE_CYC_AMPS);
      half_period = 16'(byte_period / 16'(HALF_BITS_PER_BYTE));
      tick_now = (tick_count == byte_period - 16'h0001);
      next_tick_count = tick_now ? 16'h0000 : tick_count + 16'h0001;
      next_half_count = half_count + 16'h0001;
      next_half_index = half_index;
      next_shift = shift;
      next_sending = sending;
      if (tick_now) begin
         // Data register resent each tick, rewritten or not
         next_shift = tx_data;
         next_sending = tx_enable;
         next_half_count = 16'h0000;
         next_half_index = 4'h0;
      end else if (half_count == half_period - 16'h0001) begin
         next_half_count = 16'h0000;
         next_half_index = half_index + 4'h1;
         if (half_index[0]) begin
            next_shift = {shift[6:0], 1'b0};
         end
      end
      if (!tx_enable) begin
         next_sending = 1'b0;
      end
      // Bit-rate square wave XOR data bit, then optional invert
      next_tx_serial = sending ? ((half_index[0] ^ shift[7]) ^ tx_invert) : 1'b0;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         tick_count <= 16'h0000;
         half_count <= 16'h0000;
         half_index <= 4'h0;
         shift <= 8'h00;
         sending <= 1'b0;
         tx_serial <= 1'b0;
         tx_tick <= 1'b0;
      end else begin
         tick_count <= next_tick_count;
         half_count <= next_half_count;
         half_index <= next_half_index;
         shift <= next_shift;
         sending <= next_sending;
         tx_serial <= next_tx_serial;
         tx_tick <= tick_now;
      end
   end
endmodule // cmws_tx

// ==== verilog/cmws_top.sv ====
/*
 Word sync detector, busy/idle extraction, receive byte assembly and register
 file for the cellular modem, with the transmit half instantiated.
 Assumes recovered bit data, bit strobe and squelch flag arrive from pins,
 and an Avalon-MM master on core_clk.
*/
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module cmws_top (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rx_bit_pin,
   input wire logic rx_bit_strobe_pin,
   input wire logic squelch_ok_pin,
   input wire logic sat_update_pin,
   output cmws_pkg::cmws_events_type events,
   output logic tx_serial
);
   import cmws_pkg::*;

   // ==========================================================
   // Helpers
   // Modes in which a Barker match restarts byte and frame counting
   function automatic logic reframes(input cmws_mode_type m);
      return (m == MODE_CC_UNSYNC) || (m == MODE_VC_REFRAME);
   endfunction

   // Squelch tally plus the approved flag of one more bit
   function automatic logic [3:0] tally(input logic [3:0] t, input logic f);
      return t + {3'h0, f};
   endfunction

   // Byte register zero-extended onto the bus word
   function automatic logic [31:0] bus_word(input logic [7:0] v);
      return {24'h000000, v};
   endfunction

   // ==========================================================
   // Pin synchronisers
   logic [3:0] sync_a, sync_b;
   logic strobe_last;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
         strobe_last <= 1'b0;
      end else begin
         sync_a <= {sat_update_pin, squelch_ok_pin, rx_bit_strobe_pin, rx_bit_pin};
         sync_b <= sync_a;
         strobe_last <= sync_b[1];
      end
   end
   logic rx_bit, bit_strobe, squelch_ok, sat_pulse;
   logic sat_last;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sat_last <= 1'b0;
      end else begin
         sat_last <= sync_b[3];
      end
   end

   // ==========================================================
   // Receive step every 50 core cycles, 500 kHz (nearest divide to 504 kHz)
   logic [7:0] rx_div, next_rx_div;
   logic rx_step, rx_step_pend, next_rx_step_pend;
   always_comb begin
      rx_bit = sync_b[0];
      squelch_ok = sync_b[2];
      sat_pulse = sync_b[3] & ~sat_last;
      rx_step = (rx_div == 8'(RX_TICK_DIV - 1));
      next_rx_div = rx_step ? 8'h00 : rx_div + 8'h01;
      next_rx_step_pend = rx_step_pend;
      if (sync_b[1] & ~strobe_last) begin
         next_rx_step_pend = 1'b1;
      end else if (rx_step) begin
         next_rx_step_pend = 1'b0;
      end
      bit_strobe = rx_step & rx_step_pend;
   end
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rx_div <= 8'h00;
         rx_step_pend <= 1'b0;
      end else begin
         rx_div <= next_rx_div;
         rx_step_pend <= next_rx_step_pend;
      end
   end

   // ==========================================================
   // Registers
   logic [7:0] control, next_control;
   logic [7:0] tx_data, next_tx_data;
   logic [7:0] sq_threshold, next_sq_threshold;
   logic [31:0] next_readdata;
   cmws_rx_byte_type rx_held, next_rx_held;
   logic busyidle, next_busyidle;
   cmws_mode_type mode;

   always_comb begin
      case ({control[CTL_CHANNEL_TYPE], control[CTL_REFRAME]})
         2'b00: mode = MODE_CC_SYNC;
         2'b01: mode = MODE_CC_UNSYNC;
         2'b10: mode = MODE_VC_FIXED;
         2'b11: mode = MODE_VC_REFRAME;
         default: mode = MODE_CC_SYNC;
      endcase
   end

   // ==========================================================
   // Word sync detector and byte assembly
   logic [10:0] barker_sr, next_barker_sr;
   logic [7:0] byte_sr, next_byte_sr;
   logic [3:0] bit_count, next_bit_count;
   logic [3:0] sq_tally, next_sq_tally;
   logic [9:0] frame_count, next_frame_count;
   logic [3:0] bi_count, next_bi_count;
   logic framed, next_framed;
   cmws_events_type next_events;
   logic barker_hit;

   always_comb begin
      next_barker_sr = barker_sr;
      next_byte_sr = byte_sr;
      next_bit_count = bit_count;
      next_sq_tally = sq_tally;
      next_frame_count = frame_count;
      next_bi_count = bi_count;
      next_framed = framed;
      next_rx_held = rx_held;
      next_busyidle = busyidle;
      next_events = '0;
      barker_hit = 1'b0;
      if (bit_strobe) begin
         next_barker_sr = {barker_sr[9:0], rx_bit};
         barker_hit = (next_barker_sr == BARKER_CODE);
         next_events.word_sync = barker_hit;
         next_frame_count = frame_count + 10'h001;
         if (frame_count == 10'(FRAME_BITS_DEFAULT - 1)) begin
            next_frame_count = 10'h000;
         end
         if (barker_hit && reframes(mode)) begin
            // Reframe: next bit starts a byte and a frame
            next_bit_count = 4'h0;
            next_sq_tally = 4'h0;
            next_frame_count = 10'h000;
            next_bi_count = 4'h0;
            next_framed = 1'b1;
         end else if (mode == MODE_CC_SYNC && framed &&
                      bi_count == 4'(BI_SPACING_DEFAULT)) begin
            // Busy/idle bit removed from the byte stream
            next_bi_count = 4'h0;
            next_busyidle = rx_bit;
            next_events.busyidle_or_sat = 1'b1;
         end else begin
            // Byte boundaries follow the counters, so Barker is skewed in data
            next_bi_count = bi_count + 4'h1;
            next_byte_sr = {byte_sr[6:0], rx_bit};
            next_sq_tally = tally(sq_tally, squelch_ok);
            next_bit_count = bit_count + 4'h1;
            if (bit_count == 4'(BITS_PER_BYTE - 1)) begin
               next_bit_count = 4'h0;
               next_sq_tally = 4'h0;
               next_rx_held.data = next_byte_sr;
               next_rx_held.squelch = tally(sq_tally, squelch_ok);
               next_events.rx_byte = 1'b1;
            end
         end
         if (mode == MODE_CC_SYNC && next_frame_count == 10'h000) begin
            next_bi_count = 4'h0;
         end
      end
      if (sat_pulse && control[CTL_CHANNEL_TYPE]) begin
         next_events.busyidle_or_sat = 1'b1;
      end
      next_events.tx_tick = 1'b0;
   end

   logic tx_tick;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         barker_sr <= 11'h000;
         byte_sr <= 8'h00;
         bit_count <= 4'h0;
         sq_tally <= 4'h0;
         frame_count <= 10'h000;
         bi_count <= 4'h0;
         framed <= 1'b0;
         rx_held <= '0;
         busyidle <= 1'b0;
         events <= '0;
      end else begin
         barker_sr <= next_barker_sr;
         byte_sr <= next_byte_sr;
         bit_count <= next_bit_count;
         sq_tally <= next_sq_tally;
         frame_count <= next_frame_count;
         bi_count <= next_bi_count;
         framed <= next_framed;
         rx_held <= next_rx_held;
         busyidle <= next_busyidle;
         events <= next_events | {3'b000, tx_tick};
      end
   end

   // ==========================================================
   // Avalon-MM slave, one wait cycle on read
   logic rd_ready, next_rd_ready;
   always_comb begin
      next_control = control;
      next_tx_data = tx_data;
      next_sq_threshold = sq_threshold;
      next_readdata = avs_readdata;
      next_rd_ready = 1'b0;
      avs_waitrequest = avs_read & ~rd_ready;
      if (avs_write) begin
         case (avs_address)
            ADDR_CONTROL: next_control = avs_writedata[7:0];
            ADDR_MODEM_PORT_ONE: next_sq_threshold = {4'h0, avs_writedata[3:0]};
            ADDR_TX_DATA: next_tx_data = avs_writedata[7:0];
            default: next_control = control;
         endcase
      end
      if (avs_read && !rd_ready) begin
         next_rd_ready = 1'b1;
         case (avs_address)
            ADDR_CONTROL: next_readdata = bus_word(control);
            ADDR_MODEM_PORT_ONE: next_readdata = {25'h0000000, busyidle, 2'b00, rx_held.squelch};
            ADDR_RX_DATA: next_readdata = bus_word(rx_held.data);
            ADDR_TX_DATA: next_readdata = bus_word(tx_data);
            ADDR_EVENTS: next_readdata = {27'h0000000, framed, events};
            default: next_readdata = 32'h00000000;
         endcase
      end
   end
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         control <= CONTROL_RESET;
         tx_data <= 8'h00;
         sq_threshold <= 8'h00;
         avs_readdata <= 32'h00000000;
         rd_ready <= 1'b0;
      end else begin
         control <= next_control;
         tx_data <= next_tx_data;
         sq_threshold <= next_sq_threshold;
         avs_readdata <= next_readdata;
         rd_ready <= next_rd_ready;
      end
   end

   // ==========================================================
   // Transmitter
   cmws_tx u_tx (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .tx_data(tx_data),
      .tx_enable(control[CTL_TX_ENABLE]),
      .tx_invert(control[CTL_TX_INVERT]),
      .system_type_select(control[CTL_SYSTEM_TYPE]),
      .tx_tick(tx_tick),
      .tx_serial(tx_serial)
   );
endmodule // cmws_top

// ==== test/cmws_monitor.sv ====
/*
 Port checker for cmws_top: bus wait states, event pulses, tick spacing.
 Assumes one core_clk domain; bound to every cmws_top below.
*/
`timescale 1ns/1ps
module cmws_monitor (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire cmws_pkg::cmws_events_type events
);
   import cmws_pkg::*;
   int gap;
   logic seen;
   // ==========================================
   // Cycles since the last transmit tick
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         gap <= 0;
         seen <= 1'b0;
      end else if (events.tx_tick) begin
         gap <= 1;
         seen <= 1'b1;
      end else begin
         gap <= gap + 1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   write_no_wait_a:
      assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
   idle_no_wait_a:
      assert property (!avs_read |-> !avs_waitrequest) else $error("idle wait");
   read_one_wait_a:
      assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read wait not one cycle");
   sync_pulse_a:
      assert property (events.word_sync |=> !events.word_sync) else $error("sync held");
   byte_pulse_a:
      assert property (events.rx_byte |=> !events.rx_byte) else $error("byte held");
   status_pulse_a:
      assert property (events.busyidle_or_sat |=> !events.busyidle_or_sat)
      else $error("status held");
   tick_pulse_a:
      assert property (events.tx_tick |=> !events.tx_tick [*8]) else $error("tick held");
   tick_period_a:
      assert property (events.tx_tick && seen |->
         gap == TX_BYTE_CYC_AMPS || gap == TX_BYTE_CYC_TACS) else $error("tick period");
endmodule // cmws_monitor
bind cmws_top cmws_monitor i_mon (.core_clk(core_clk), .reset_n(reset_n),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .events(events));

// ==== test/cmws_radio_model.sv ====
/*
 Radio side model: plays queued bits with strobe and squelch flag, SAT pulse.
 Assumes bits are queued by the bench through push.
*/
`timescale 1ns/1ps
module cmws_radio_model (
   input wire logic core_clk,
   output logic rx_bit_pin,
   output logic rx_bit_strobe_pin,
   output logic squelch_ok_pin,
   output logic sat_update_pin
);
   logic [1:0] q[$];
   logic [1:0] cur;
   int ph = 0;
   initial begin
      rx_bit_pin = 1'b0;
      rx_bit_strobe_pin = 1'b0;
      squelch_ok_pin = 1'b0;
      sat_update_pin = 1'b0;
   end
   // Idle line toggles so no stale bit is seen
   always @(posedge core_clk) begin
      if (ph == 0) begin
         if (q.size() != 0) begin
            cur = q.pop_front();
            rx_bit_pin <= cur[1];
            squelch_ok_pin <= cur[0];
            ph <= 1;
         end else begin
            rx_bit_pin <= ~rx_bit_pin;
            squelch_ok_pin <= ~squelch_ok_pin;
         end
      end else begin
         ph <= (ph == 120) ? 0 : ph + 1;
         rx_bit_strobe_pin <= (ph >= 4 && ph < 64);
      end
   end
   task automatic push(input logic b, input logic s);
      q.push_back({b, s});
   endtask
   task automatic sat_pulse();
      @(posedge core_clk);
      sat_update_pin <= 1'b1;
      repeat (8) @(posedge core_clk);
      sat_update_pin <= 1'b0;
   endtask
endmodule // cmws_radio_model

// ==== test/cmws_top_tb_top.sv ====
/*
 Self-checking bench for cmws_top with a byte model built from queues.
 Assumes the monitor bind and the radio model are compiled first.
*/
`timescale 1ns/1ps
module cmws_top_tb_top;
   import cmws_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic rx_bit_pin, rx_bit_strobe_pin, squelch_ok_pin, sat_update_pin, tx_serial;
   cmws_events_type events;
   logic [16:0] lfsr = 17'h11eee;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int ev_n [4] = '{0, 0, 0, 0};
   logic [31:0] rd;
   logic [7:0] acc, txd;
   int nb = 0;
   int sqc = 0;
   logic [7:0] q_byte[$];
   int q_sq[$];
   always #20 core_clk = ~core_clk;
   cmws_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rx_bit_pin(rx_bit_pin), .rx_bit_strobe_pin(rx_bit_strobe_pin),
      .squelch_ok_pin(squelch_ok_pin), .sat_update_pin(sat_update_pin),
      .events(events), .tx_serial(tx_serial));
   cmws_radio_model i_radio (.core_clk(core_clk), .rx_bit_pin(rx_bit_pin),
      .rx_bit_strobe_pin(rx_bit_strobe_pin), .squelch_ok_pin(squelch_ok_pin),
      .sat_update_pin(sat_update_pin));
   // ==========================================
   // Event counters and run limit
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      for (int i = 0; i < 4; i++) ev_n[i] <= ev_n[i] + int'(events[i]);
      if (cyc == 100000) begin
         bad_count++;
         conclude();
      end
   end
   function automatic logic rnd();
      lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
      return lfsr[0];
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wait_ev(input int i);
      int s;
      int k;
      s = ev_n[i];
      k = 0;
      // Long enough to span a full transmit tick period
      while (ev_n[i] == s && k < 30000) begin
         @(posedge core_clk);
         k++;
      end
      check(k < 30000, 1);
   endtask
   // Queue bits; data bits are random and enter the byte model
   task automatic send(input logic [15:0] v, input int n, input logic data);
      logic b;
      logic s;
      for (int i = n - 1; i >= 0; i--) begin
         b = data ? rnd() : v[i];
         s = rnd();
         i_radio.push(b, s);
         if (data) begin
            acc = {acc[6:0], b};
            sqc += int'(s);
            nb++;
            if (nb == BITS_PER_BYTE) begin
               q_byte.push_back(acc);
               q_sq.push_back(sqc);
               nb = 0;
               sqc = 0;
            end
         end
      end
   endtask
   task automatic got_byte();
      wait_ev(2);
      bus(1'b0, ADDR_RX_DATA, 8'h00);
      check(rd[7:0], q_byte.pop_front());
      bus(1'b0, ADDR_MODEM_PORT_ONE, 8'h00);
      check(rd[3:0], q_sq.pop_front());
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      bus(1'b0, ADDR_CONTROL, 8'h00);
      check(rd, {24'h0, CONTROL_RESET});
      bus(1'b0, 4'hf, 8'h00);
      check(rd, 32'h0);
      bus(1'b1, ADDR_CONTROL, 8'h02);
      send(16'haaaa, 16, 1'b0);
      send({5'h0, BARKER_CODE}, 11, 1'b0);
      send(16'h0, 10, 1'b1);
      send(16'h1, 1, 1'b0);
      send(16'h0, 10, 1'b1);
      send(16'h0, 1, 1'b0);
      send(16'h0, 4, 1'b1);
      wait_ev(3);
      bus(1'b1, ADDR_CONTROL, 8'h00);
      got_byte();
      wait_ev(1);
      bus(1'b0, ADDR_MODEM_PORT_ONE, 8'h00);
      check(rd[MP1_BUSYIDLE], 1'b1);
      got_byte();
      wait_ev(1);
      bus(1'b0, ADDR_MODEM_PORT_ONE, 8'h00);
      check(rd[MP1_BUSYIDLE], 1'b0);
      got_byte();
      for (int m = 1; m < 4; m += 2) begin
         bus(1'b1, ADDR_CONTROL, 8'(m));
         fork
            i_radio.sat_pulse();
            wait_ev(1);
         join
         send({5'h0, BARKER_CODE}, 11, 1'b0);
         wait_ev(3);
      end
      send(16'h0, 8, 1'b1);
      got_byte();
      for (int i = 0; i < 8; i++) txd[i] = rnd();
      bus(1'b1, ADDR_TX_DATA, txd);
      bus(1'b0, ADDR_TX_DATA, 8'h00);
      check(rd[7:0], txd);
      bus(1'b1, ADDR_CONTROL, 8'h08);
      for (int inv = 0; inv < 2; inv++) begin
         wait_ev(0);
         for (int h = 0; h < HALF_BITS_PER_BYTE; h++) begin
            repeat (h == 0 ? 625 : TX_BYTE_CYC_AMPS / HALF_BITS_PER_BYTE) @(posedge core_clk);
            check(tx_serial, txd[7 - h / 2] ^ h[0] ^ inv[0]);
         end
         if (inv == 0) bus(1'b1, ADDR_CONTROL, 8'h48);
      end
      conclude();
   end
endmodule // cmws_top_tb_top
